// file: dtp_pkg.sv
package dtp_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_COUNT_VALUE = 6'h09;
  localparam logic [5:0] IDX_CTRL_ONE = 6'h0a;
  localparam logic [5:0] IDX_CTRL_TWO = 6'h0b;
  localparam logic [5:0] IDX_PWM_DUTY = 6'h0c;
  localparam logic [5:0] IDX_PRESCALER = 6'h0d;
  localparam logic [5:0] IDX_SHARED_HIGH = 6'h10;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h12;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 10;

  // reset values and counter limits
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h3f;
  localparam logic [7:0] PRESCALER_RST = 8'hff;
  localparam logic [7:0] RELOAD_LOW_RST = 8'hff;
  localparam logic [7:0] DUTY_LOW_RST = 8'h00;
  localparam logic [7:0] SHARED_HIGH_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST = 10'h3ff;
  localparam logic [CNT_W-1:0] COUNT_MAX = 10'h3ff;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 10'h000;

  // writable bit masks; reserved bits read as zero
  localparam logic [7:0] CTRL_ONE_MASK = 8'hef;
  localparam logic [7:0] CTRL_TWO_MASK = 8'h3f;

  // shared high bits register field positions
  localparam int SH_COUNT_HI = 7;
  localparam int SH_COUNT_LO = 6;
  localparam int SH_DUTY_HI = 3;
  localparam int SH_DUTY_LO = 2;

  // interrupt status bit of the underflow event
  localparam int IRQ_UNDERFLOW = 0;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h01;

  typedef struct packed {
    logic pwm_output_enable;
    logic pwm_polarity;
    logic toggle_output_enable;
    logic rsvd;
    logic shared_fast_clock_select;
    logic one_shot_select;
    logic reload_select;
    logic timer_run_enable;
  } dtp_ctrl_one_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic source_select;
    logic external_edge_select;
    logic prescaler_disable_n;
    logic [2:0] prescaler_rate_field;
  } dtp_ctrl_two_t;

  // pad group carried together
  typedef struct packed {
    logic pwm_channel_out;
    logic pwm_oe;
    logic timer_toggle_output;
    logic toggle_oe;
  } dtp_pads_t;

endpackage : dtp_pkg

// file: dtp_timer.sv
// Functional notes
// - count read returns live low byte
// - count write loads high bits plus reload
// - fast select clocks timer from high oscillator
// - free run, select 0: wrap to 0x3FF
// - free run, select 1: reload stored value
// - one-shot stops at zero on underflow
// - polarity bit one makes PWM active low
// - PWM enable drives pins, else GPIO
// - toggle output inverts each underflow when enabled
// - rate codes divide by 2 to 256
// - edge select: one falling, zero rising
// - source select picks external pin when set
// - reload sets period, duty sets width
// - prescaler count readable, resets to all ones
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module dtp_timer
  import dtp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [dtp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dtp_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dtp_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic instr_clk_tick,
  input wire logic hosc_tick,
  input wire logic external_clock_pin,
  output logic shared_fast_clock_select,
  output dtp_pkg::dtp_pads_t pads,
  output logic irq
);
  import dtp_pkg::*;

  // divider mask for a rate code: 2^(code+1) - 1
  function automatic logic [7:0] rate_mask(input logic [2:0] code);
    rate_mask = 8'hff >> (3'h7 - code);
  endfunction : rate_mask

  dtp_ctrl_one_t ctrl_one;
  dtp_ctrl_two_t ctrl_two;
  logic [7:0] shared_high;
  logic [7:0] reload_low;
  logic [7:0] duty_low;
  logic [7:0] prescaler;
  logic [CNT_W-1:0] count;
  logic stopped;
  logic ext_prev;
  logic ack;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic pwm_out;
  logic pwm_oe;
  logic toggle_out;
  logic toggle_oe;

  // bus decode
  wire logic [5:0] idx = avs_address[ADDR_W-1:2];
  wire logic req = avs_read | avs_write;
  wire logic accept = req & ack;
  wire logic wr_lane = accept & avs_write & avs_byteenable[0];
  wire logic rd_acc = accept & avs_read;
  wire logic [7:0] wbyte = avs_writedata[7:0];
  wire logic wr_count = wr_lane & (idx == IDX_COUNT_VALUE);
  wire logic wr_ctrl_one = wr_lane & (idx == IDX_CTRL_ONE);
  wire logic wr_ctrl_two = wr_lane & (idx == IDX_CTRL_TWO);
  wire logic wr_duty = wr_lane & (idx == IDX_PWM_DUTY);
  wire logic wr_shared = wr_lane & (idx == IDX_SHARED_HIGH);
  wire logic wr_mask = wr_lane & (idx == IDX_IRQ_MASK);
  wire logic rd_status = rd_acc & (idx == IDX_IRQ_STATUS);

  // one wait cycle keeps the read mux off the combinational path
  assign avs_waitrequest = req & ~ack;

  // assembled 10-bit values
  wire logic [CNT_W-1:0] reload_val = {shared_high[SH_COUNT_HI:SH_COUNT_LO], reload_low};
  wire logic [CNT_W-1:0] duty_val = {shared_high[SH_DUTY_HI:SH_DUTY_LO], duty_low};
  wire logic [CNT_W-1:0] load_val = {shared_high[SH_COUNT_HI:SH_COUNT_LO], wbyte};

  // clock source selection; the pin is already synchronous to ref_clk
  wire logic ext_rise = external_clock_pin & ~ext_prev;
  wire logic ext_fall = ~external_clock_pin & ext_prev;
  wire logic ext_tick = ctrl_two.external_edge_select ? ext_fall : ext_rise;
  wire logic slow_tick = ctrl_two.source_select ? ext_tick : instr_clk_tick;
  wire logic src_tick = ctrl_one.shared_fast_clock_select ? hosc_tick : slow_tick;

  // prescaler: counts source ticks, fires when the selected low bits reach zero
  wire logic ps_on = ~ctrl_two.prescaler_disable_n;
  wire logic [7:0] ps_mask = rate_mask(ctrl_two.prescaler_rate_field);
  wire logic ps_fire = ((prescaler & ps_mask) == 8'h00);
  wire logic [7:0] next_prescaler = (ps_on & src_tick) ? prescaler - 8'h01 : prescaler;
  // disabled prescaler passes the source straight through
  wire logic timer_tick = ps_on ? (src_tick & ps_fire) : src_tick;

  // counter step
  // run gate
  wire logic step = timer_tick & ctrl_one.timer_run_enable & ~stopped;
  wire logic at_zero = (count == COUNT_ZERO);
  wire logic underflow = step & at_zero;
  wire logic [CNT_W-1:0] wrap_val = ctrl_one.reload_select ? reload_val : COUNT_MAX;
  logic [CNT_W-1:0] next_count;
  logic next_stopped;

  // counter next value; a software load wins over a tick
  always_comb
  begin
    next_count = count;
    next_stopped = stopped;
    if (wr_count)
    begin
      next_count = load_val;
      next_stopped = 1'b0;
    end
    else if (underflow)
    begin
      if (ctrl_one.one_shot_select)
      begin
        next_stopped = 1'b1;
      end
      else
      begin
        next_count = wrap_val;
      end
    end
    else if (step)
    begin
      next_count = count - 10'h001;
    end
    if (wr_ctrl_one)
    begin
      next_stopped = 1'b0; // rewriting control rearms a stopped one-shot
    end
  end

  // pwm level, computed then registered
  // active while below duty
  wire logic pwm_active = (count < duty_val);
  wire logic next_pwm_out = pwm_active ^ ctrl_one.pwm_polarity;
  wire logic next_toggle = underflow ? ~toggle_out : toggle_out;

  // interrupt status: set wins over read clear; only bits the read reported are cleared,
  // so an event landing between the data snapshot and the accept edge is not lost
  wire logic [7:0] irq_set = {7'h00, underflow};
  wire logic [7:0] irq_seen = rd_status ? avs_readdata[7:0] : 8'h00;
  wire logic [7:0] next_irq_status = (irq_status & ~irq_seen) | irq_set;
  assign irq = |(irq_status & irq_mask);

  // read mux
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx)
      IDX_COUNT_VALUE: rd_byte = count[7:0];
      IDX_CTRL_ONE: rd_byte = ctrl_one & CTRL_ONE_MASK;
      IDX_CTRL_TWO: rd_byte = ctrl_two & CTRL_TWO_MASK;
      IDX_PWM_DUTY: rd_byte = 8'h00; // write-only
      IDX_PRESCALER: rd_byte = prescaler;
      IDX_SHARED_HIGH: rd_byte = shared_high;
      IDX_IRQ_STATUS: rd_byte = irq_status;
      IDX_IRQ_MASK: rd_byte = irq_mask;
      default: rd_byte = 8'h00;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack <= 1'b0;
      avs_readdata <= '0;
    end
    else
    begin
      ack <= req & ~ack;
      if (req & ~ack)
      begin
        avs_readdata <= {24'h000000, rd_byte};
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_one <= CTRL_ONE_RST;
      ctrl_two <= CTRL_TWO_RST;
      shared_high <= SHARED_HIGH_RST;
      reload_low <= RELOAD_LOW_RST;
      duty_low <= DUTY_LOW_RST;
      irq_mask <= 8'h00;
    end
    else
    begin
      if (wr_ctrl_one) ctrl_one <= wbyte & CTRL_ONE_MASK;
      // rate change is software's duty; logic takes it at once
      if (wr_ctrl_two) ctrl_two <= wbyte & CTRL_TWO_MASK;
      if (wr_shared) shared_high <= wbyte;
      if (wr_count) reload_low <= wbyte;
      if (wr_duty) duty_low <= wbyte;
      if (wr_mask) irq_mask <= wbyte & IRQ_MASK_BITS;
    end
  end

  // counting state and pads
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescaler <= PRESCALER_RST;
      count <= COUNT_RST;
      stopped <= 1'b0;
      ext_prev <= 1'b0;
      irq_status <= 8'h00;
      pwm_out <= 1'b0;
      pwm_oe <= 1'b0;
      toggle_out <= 1'b0;
      toggle_oe <= 1'b0;
    end
    else
    begin
      prescaler <= next_prescaler;
      count <= next_count;
      stopped <= next_stopped;
      ext_prev <= external_clock_pin;
      irq_status <= next_irq_status;
      pwm_out <= next_pwm_out;
      pwm_oe <= ctrl_one.pwm_output_enable;
      toggle_out <= next_toggle;
      toggle_oe <= ctrl_one.toggle_output_enable;
    end
  end

  assign shared_fast_clock_select = ctrl_one.shared_fast_clock_select;
  assign pads.pwm_channel_out = pwm_out;
  assign pads.pwm_oe = pwm_oe;
  assign pads.timer_toggle_output = toggle_out;
  assign pads.toggle_oe = toggle_oe;

  // checks
  chk_read_live: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req & ~ack & avs_read & (idx == IDX_COUNT_VALUE)) |=> (avs_readdata[7:0] == $past(count[7:0])))
    else $error("count read does not show live counter");
  chk_write_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_count |=> (count == {$past(shared_high[SH_COUNT_HI:SH_COUNT_LO]), $past(wbyte)}))
    else $error("count write did not load ten bits");
  chk_fast_source: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ctrl_one.shared_fast_clock_select |-> (src_tick == hosc_tick))
    else $error("fast select not using high oscillator");
  chk_wrap_max: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (underflow & ~wr_count & ~ctrl_one.one_shot_select & ~ctrl_one.reload_select)
      |=> (count == COUNT_MAX))
    else $error("free run did not wrap to maximum");
  chk_wrap_reload: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (underflow & ~wr_count & ~ctrl_one.one_shot_select & ctrl_one.reload_select)
      |=> (count == $past(reload_val)))
    else $error("free run did not reload stored value");
  chk_one_shot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (underflow & ~wr_count & ~wr_ctrl_one & ctrl_one.one_shot_select)
      |=> (stopped && count == COUNT_ZERO)
      ##1 ($past(wr_count | wr_ctrl_one) || (stopped && count == COUNT_ZERO)))
    else $error("one-shot did not stop at zero");
  chk_pwm_level: assert property (@(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> (pwm_out == ($past(count < duty_val) ^ $past(ctrl_one.pwm_polarity))))
    else $error("pwm level or polarity wrong");
  chk_pwm_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(ctrl_one.pwm_output_enable) |=> pads.pwm_oe)
    else $error("pwm enable did not reach pin");
  chk_toggle_flip: assert property (@(posedge ref_clk) disable iff (!rst_b)
    underflow |=> (toggle_out != $past(toggle_out)))
    else $error("toggle output did not invert");
  chk_prescale_fire: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ps_on & ((prescaler & ps_mask) != 8'h00)) |-> !timer_tick)
    else $error("prescaler fired early");
  chk_edge_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ctrl_two.external_edge_select & ext_rise) |-> !ext_tick)
    else $error("rising edge counted in falling mode");
  chk_run_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (~ctrl_one.timer_run_enable & ~wr_count) |=> $stable(count))
    else $error("counter moved while disabled");
  chk_irq_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    underflow |=> irq_status[IRQ_UNDERFLOW])
    else $error("underflow lost from status");
  chk_ps_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ~ps_on |=> $stable(prescaler))
    else $error("disabled prescaler moved");
  chk_ps_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (ps_on & src_tick) |=> (prescaler == $past(prescaler) - 8'h01))
    else $error("enabled prescaler did not count");
  chk_stop_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (stopped & ~wr_count & ~wr_ctrl_one) |=> (stopped && $stable(count)))
    else $error("stopped one-shot moved");
  chk_pwm_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(ctrl_one.pwm_output_enable) |=> !pads.pwm_oe)
    else $error("pwm pins not released");
  chk_toggle_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !underflow |=> $stable(toggle_out))
    else $error("toggle output moved without underflow");
  chk_toggle_pad: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ctrl_one.toggle_output_enable |=> pads.toggle_oe)
    else $error("toggle pad not enabled");
  chk_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rd_status & ~underflow & avs_readdata[IRQ_UNDERFLOW]) |=> !irq_status[IRQ_UNDERFLOW])
    else $error("reported status bit not cleared by read");
  chk_instr_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (instr_clk_tick & ~ctrl_two.source_select & ~ctrl_one.shared_fast_clock_select & ~ps_on
      & ctrl_one.timer_run_enable & ~stopped & ~wr_count & ~at_zero)
      |=> (count == $past(count) - 10'h001))
    else $error("instruction tick did not step counter");
  chk_rise_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (external_clock_pin & ~$past(external_clock_pin) & ctrl_two.source_select
      & ~ctrl_two.external_edge_select & ~ctrl_one.shared_fast_clock_select & ~ps_on
      & ctrl_one.timer_run_enable & ~stopped & ~wr_count & ~at_zero)
      |=> (count == $past(count) - 10'h001))
    else $error("rising pin edge did not step counter");

  cov_underflow_wrap: cover property (@(posedge ref_clk) disable iff (!rst_b)
    underflow ##1 step);
  cov_one_shot_stop: cover property (@(posedge ref_clk) disable iff (!rst_b)
    underflow & ctrl_one.one_shot_select);
  cov_irq_raise: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq));
  cov_ext_count: cover property (@(posedge ref_clk) disable iff (!rst_b)
    ctrl_two.source_select & step);
  cov_reload_stored: cover property (@(posedge ref_clk) disable iff (!rst_b)
    underflow & ctrl_one.reload_select & ~ctrl_one.one_shot_select);

endmodule : dtp_timer

`default_nettype wire

// file: dtp_far_side.sv
`timescale 1ns/100ps
`default_nettype none

// stands in for the instruction clock, the high oscillator and the external pin
module dtp_far_side
(
  input wire logic ref_clk,
  output logic instr_clk_tick,
  output logic hosc_tick,
  output logic external_clock_pin
);
  // quiet sources at time zero; the pin idles low between pulses
  initial
  begin
    instr_clk_tick = 1'b0;
    hosc_tick = 1'b0;
    external_clock_pin = 1'b0;
  end

  // src 0 instruction tick, 1 high oscillator tick, else the pin
  task automatic drive(input int src, input logic lvl);
    @(posedge ref_clk);
    if (src == 0)
      instr_clk_tick <= lvl;
    else if (src == 1)
      hosc_tick <= lvl;
    else
      external_clock_pin <= lvl;
  endtask : drive

  // one rise, one fall
  // a gap cycle after each pulse keeps every tick a single cycle wide
  task automatic pulse(input int src, input int n);
    repeat (n)
    begin
      drive(src, 1'b1);
      drive(src, 1'b0);
    end
    repeat (3) @(negedge ref_clk);
  endtask : pulse

  // single pin transition, then let the edge detector and counter settle
  task automatic level(input logic lvl);
    drive(2, lvl);
    repeat (3) @(negedge ref_clk);
  endtask : level
endmodule : dtp_far_side

`default_nettype wire

// file: dtp_timer_test.sv
`timescale 1ns/100ps
`default_nettype none

module dtp_timer_test;
  import dtp_pkg::*;
  logic ref_clk;
  logic rst_b;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic instr_clk_tick;
  logic hosc_tick;
  logic external_clock_pin;
  logic shared_fast_clock_select;
  dtp_pads_t pads;
  logic irq;
  logic [7:0] v;
  logic [7:0] p0;
  logic tog;
  int err_count;
  int checks_done;

  dtp_timer i_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .instr_clk_tick(instr_clk_tick),
    .hosc_tick(hosc_tick),
    .external_clock_pin(external_clock_pin),
    .shared_fast_clock_select(shared_fast_clock_select),
    .pads(pads),
    .irq(irq)
  );

  dtp_far_side i_far (
    .ref_clk(ref_clk),
    .instr_clk_tick(instr_clk_tick),
    .hosc_tick(hosc_tick),
    .external_clock_pin(external_clock_pin)
  );

  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  // request stands until waitrequest is sampled low at a rising edge; read data taken there
  // only the watchdog ends a wait that never finishes
  task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h000000, wd};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge ref_clk);
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d, v);
  endtask : wr

  task automatic rc(input logic [5:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00, v);
    chk8(v, exp);
  endtask : rc

  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask : settle

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // the run needs under 5000 cycles; this cuts a hang short
  initial
  begin
    #200000;
    err_count++;
    end_sim();
  end

  initial
  begin
    rst_b = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    err_count = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    // reset values, a read-only register and an unmapped place
    rc(IDX_PRESCALER, 8'hff);
    rc(IDX_CTRL_TWO, CTRL_TWO_RST);
    wr(IDX_PRESCALER, 8'h12);
    rc(IDX_PRESCALER, 8'hff);
    rc(6'h20, 8'h00);
    // a write with byte lane 0 off is acknowledged but leaves the register alone
    avs_byteenable <= 4'h0;
    wr(IDX_SHARED_HIGH, 8'h55);
    avs_byteenable <= 4'h1;
    rc(IDX_SHARED_HIGH, SHARED_HIGH_RST);
    // rising pin edges, prescaler off; 0x102 must not underflow in three edges
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CTRL_TWO, 8'h28);
    wr(IDX_CTRL_ONE, 8'h21);
    wr(IDX_SHARED_HIGH, 8'h40);
    wr(IDX_COUNT_VALUE, 8'h02);
    rc(IDX_COUNT_VALUE, 8'h02);
    i_far.pulse(2, 3);
    rc(IDX_COUNT_VALUE, 8'hff);
    rc(IDX_IRQ_STATUS, 8'h00);
    // wrap to full scale, toggle flips, interrupt raised then read-cleared
    wr(IDX_SHARED_HIGH, 8'h00);
    wr(IDX_COUNT_VALUE, 8'h02);
    tog = pads.timer_toggle_output;
    i_far.pulse(2, 3);
    chk1(irq, 1'b1);
    chk1(pads.timer_toggle_output, ~tog);
    chk1(pads.toggle_oe, 1'b1);
    rc(IDX_COUNT_VALUE, 8'hff);
    rc(IDX_IRQ_STATUS, 8'h01);
    settle();
    chk1(irq, 1'b0);
    rc(IDX_IRQ_STATUS, 8'h00);
    // stored reload value, interrupt masked
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_CTRL_ONE, 8'h23);
    wr(IDX_COUNT_VALUE, 8'h01);
    i_far.pulse(2, 2);
    rc(IDX_COUNT_VALUE, 8'h01);
    chk1(irq, 1'b0);
    tog = pads.timer_toggle_output;
    i_far.pulse(2, 2);
    rc(IDX_COUNT_VALUE, 8'h01);
    chk1(pads.timer_toggle_output, ~tog);
    rc(IDX_IRQ_STATUS, 8'h01);
    // one-shot holds zero even with reload select set
    wr(IDX_CTRL_ONE, 8'h27);
    wr(IDX_COUNT_VALUE, 8'h01);
    i_far.pulse(2, 5);
    rc(IDX_COUNT_VALUE, 8'h00);
    wr(IDX_CTRL_ONE, 8'h20);
    wr(IDX_COUNT_VALUE, 8'h05);
    i_far.pulse(2, 3);
    rc(IDX_COUNT_VALUE, 8'h05);
    // falling edge select, then rising edge select
    wr(IDX_CTRL_ONE, 8'h21);
    wr(IDX_CTRL_TWO, 8'h38);
    i_far.level(1'b1);
    rc(IDX_COUNT_VALUE, 8'h05);
    i_far.level(1'b0);
    rc(IDX_COUNT_VALUE, 8'h04);
    wr(IDX_CTRL_TWO, 8'h28);
    i_far.level(1'b1);
    rc(IDX_COUNT_VALUE, 8'h03);
    i_far.level(1'b0);
    rc(IDX_COUNT_VALUE, 8'h03);
    // clock source: instruction tick, then the shared fast select overrides the pin
    wr(IDX_CTRL_TWO, 8'h08);
    wr(IDX_COUNT_VALUE, 8'h10);
    i_far.pulse(1, 3);
    rc(IDX_COUNT_VALUE, 8'h10);
    i_far.pulse(0, 3);
    rc(IDX_COUNT_VALUE, 8'h0d);
    wr(IDX_CTRL_TWO, 8'h28);
    wr(IDX_CTRL_ONE, 8'h29);
    settle();
    chk1(shared_fast_clock_select, 1'b1);
    i_far.pulse(0, 2);
    i_far.pulse(2, 2);
    rc(IDX_COUNT_VALUE, 8'h0d);
    i_far.pulse(1, 2);
    rc(IDX_COUNT_VALUE, 8'h0b);
    // each rate code: 2^(c+1) edges give one count whatever the prescaler phase
    wr(IDX_CTRL_ONE, 8'h21);
    wr(IDX_COUNT_VALUE, 8'h20);
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_CTRL_TWO, 8'h28 | 8'(c));
      wr(IDX_CTRL_TWO, 8'h20 | 8'(c));
      acc(1'b0, IDX_PRESCALER, 8'h00, p0);
      i_far.pulse(2, 2 << c);
      rc(IDX_PRESCALER, p0 - 8'(2 << c));
      rc(IDX_COUNT_VALUE, 8'h1f - 8'(c));
    end
    // pwm against a duty with a high bit, both polarities, then pins released
    wr(IDX_CTRL_ONE, 8'h80);
    wr(IDX_SHARED_HIGH, 8'h04);
    wr(IDX_COUNT_VALUE, 8'h05);
    wr(IDX_PWM_DUTY, 8'h03);
    settle();
    chk1(pads.pwm_oe, 1'b1);
    chk1(pads.pwm_channel_out, 1'b1);
    wr(IDX_CTRL_ONE, 8'hc0);
    settle();
    chk1(pads.pwm_channel_out, 1'b0);
    wr(IDX_SHARED_HIGH, 8'h00);
    settle();
    chk1(pads.pwm_channel_out, 1'b1);
    wr(IDX_CTRL_ONE, 8'h00);
    settle();
    chk1(pads.pwm_oe, 1'b0);
    rc(IDX_PWM_DUTY, 8'h00);
    end_sim();
  end
endmodule : dtp_timer_test

`default_nettype wire
